//--- core/bscr_top.sv
module bscr_top #(
    parameter logic [7:0] VERSION = bscr_pkg::VERSION_CODE
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [bscr_pkg::ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [bscr_pkg::DAT_W-1:0] WB_DAT_I,
    output logic [bscr_pkg::DAT_W-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [7:0] ROTARY_POS,
    input wire logic BOOT_PROTECT_SWITCH,
    input wire logic USER_PROTECT_SWITCH,
    input wire logic FRONT_TERMINATION_SWITCH,
    input wire logic BACKPLANE_TERMINATION_SWITCH,
    input wire logic FRONT_CABLE_PRESENT,
    input wire logic [bscr_pkg::RST_W-1:0] RESET_CAUSE,
    input wire logic ENUM1_N,
    input wire logic ENUM2_N,
    input wire logic WATCHDOG_EXPIRY_OUTPUT_N,
    input wire logic TEMP1_ALARM_N,
    input wire logic TEMP2_ALARM_N,
    output logic [7:0] LED1_CTRL,
    output logic [7:0] LED2_CTRL,
    output logic [7:0] IDPROM_CTRL,
    output logic [1:0] BOOT_ROM_SIZE,
    output logic [1:0] USER_ROM_SIZE,
    output logic [7:0] SEG_DISPLAY,
    output logic MFIO_POWER_DOWN,
    output logic FLOPPY_EJECT,
    output logic WATCHDOG_KICK,
    output logic FRONT_TERM_EN,
    output logic IRQ
);
    bscr_pkg::bscr_bus_t bus_r;
    bscr_pkg::bscr_bus_t bus_nxt;
    logic req;
    logic wr_req;
    logic rd_req;
    logic lane0;
    logic [7:0] wbyte;
    logic [bscr_pkg::ADR_W-1:0] adr;
    logic [bscr_pkg::DAT_W-1:0] rdata_nxt;
    logic [bscr_pkg::DAT_W-1:0] rdata_r;
    logic ack_r;
    logic [7:0] led1_r;
    logic [7:0] led2_r;
    logic [7:0] idprom_r;
    logic [1:0] boot_size_r;
    logic [1:0] user_size_r;
    logic [7:0] display_r;
    logic [7:0] shadow_r;
    logic pwdn_r;
    logic eject_r;
    logic rst_clr_r;
    logic kick_r;
    logic term_en_r;
    logic [bscr_pkg::RST_W-1:0] rst_stat_r;
    logic [bscr_pkg::NSRC-1:0] irq_en_r;
    logic sw_wr_r;
    logic [1:0] sw_val_r;

    bscr_irq_if irq_bus ();

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state, ack dropped the cycle after it is given
    assign req = WB_CYC_I & WB_STB_I & (bus_r == bscr_pkg::BUS_IDLE);
    assign wr_req = req & WB_WE_I;
    assign rd_req = req & ~WB_WE_I;
    // No register is wider than a byte, so only lane 0 carries write data
    assign lane0 = WB_SEL_I[0];
    assign wbyte = WB_DAT_I[7:0];
    assign adr = WB_ADR_I;

    always_comb begin
        bus_nxt = bus_r;
        case (bus_r)
            bscr_pkg::BUS_IDLE: begin
                if (req) begin
                    bus_nxt = bscr_pkg::BUS_ACK;
                end
            end
            bscr_pkg::BUS_ACK: begin
                bus_nxt = bscr_pkg::BUS_IDLE;
            end
            default: begin
                bus_nxt = bscr_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            bus_r <= bscr_pkg::BUS_IDLE;
            ack_r <= 1'b0;
        end else begin
            bus_r <= bus_nxt;
            ack_r <= req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Plain byte registers and the two 2-bit ROM size registers
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            led1_r <= bscr_pkg::RST_BYTE;
            led2_r <= bscr_pkg::RST_BYTE;
            idprom_r <= bscr_pkg::RST_BYTE;
        end else if (wr_req && lane0) begin
            if (adr == bscr_pkg::OFS_LED1) begin
                led1_r <= wbyte;
            end else if (adr == bscr_pkg::OFS_LED2) begin
                led2_r <= wbyte;
            end else if (adr == bscr_pkg::OFS_IDPROM) begin
                idprom_r <= wbyte;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            boot_size_r <= bscr_pkg::RST_SIZE;
            user_size_r <= bscr_pkg::RST_SIZE;
        end else if (wr_req && lane0) begin
            if (adr == bscr_pkg::OFS_BOOT_SIZE) begin
                boot_size_r <= wbyte[1:0];
            end else if (adr == bscr_pkg::OFS_USER_SIZE) begin
                user_size_r <= wbyte[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Display drive and its shadow; only the shadow is ever read
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            display_r <= bscr_pkg::RST_BYTE;
            shadow_r <= bscr_pkg::RST_BYTE;
        end else if (wr_req && lane0 && adr == bscr_pkg::OFS_DISPLAY) begin
            display_r <= wbyte;
            shadow_r <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Miscellaneous control bits
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            pwdn_r <= 1'b0;
            eject_r <= 1'b0;
            kick_r <= 1'b0;
        end else if (wr_req && lane0 && adr == bscr_pkg::OFS_MISC) begin
            pwdn_r <= wbyte[bscr_pkg::MISC_PWDN];
            // Eject is held as written; software must drop it again itself
            eject_r <= wbyte[bscr_pkg::MISC_EJECT];
            // The watchdog restarts on any change of this level
            kick_r <= wbyte[bscr_pkg::MISC_KICK];
        end
    end

    // Clear control lives one cycle only, so it always reads back false
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            rst_clr_r <= 1'b0;
        end else begin
            rst_clr_r <= wr_req & lane0 & (adr == bscr_pkg::OFS_MISC)
                & wbyte[bscr_pkg::MISC_RST_CLR];
        end
    end

    // Reset causes are sticky; a cause seen while clearing stays set
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            rst_stat_r <= '0;
        end else if (rst_clr_r) begin
            rst_stat_r <= RESET_CAUSE;
        end else begin
            rst_stat_r <= rst_stat_r | RESET_CAUSE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Front termination: automatic mode enables only with no cable present
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            term_en_r <= 1'b0;
        end else begin
            term_en_r <= FRONT_TERMINATION_SWITCH & ~FRONT_CABLE_PRESENT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt enables and software pending writes
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            irq_en_r <= bscr_pkg::RST_EN;
        end else if (wr_req && lane0 && adr == bscr_pkg::OFS_IRQ_EN) begin
            irq_en_r <= wbyte[bscr_pkg::NSRC-1:0];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            sw_wr_r <= 1'b0;
            sw_val_r <= 2'h0;
        end else begin
            sw_wr_r <= wr_req & lane0 & (adr == bscr_pkg::OFS_IRQ_PEND);
            sw_val_r <= {wbyte[bscr_pkg::SRC_ENUM2], wbyte[bscr_pkg::SRC_ENUM1]};
        end
    end

    assign irq_bus.en = irq_en_r;
    assign irq_bus.sw_wr = sw_wr_r;
    assign irq_bus.sw_val = sw_val_r;

    bscr_irq u_irq (
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .enum1_n(ENUM1_N),
        .enum2_n(ENUM2_N),
        .wdo_n(WATCHDOG_EXPIRY_OUTPUT_N),
        .temp1_n(TEMP1_ALARM_N),
        .temp2_n(TEMP2_ALARM_N),
        .bus(irq_bus.src)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped addresses answer with zero
    always_comb begin
        rdata_nxt = '0;
        if (adr == bscr_pkg::OFS_LED1) begin
            rdata_nxt[7:0] = led1_r;
        end else if (adr == bscr_pkg::OFS_LED2) begin
            rdata_nxt[7:0] = led2_r;
        end else if (adr == bscr_pkg::OFS_IDPROM) begin
            rdata_nxt[7:0] = idprom_r;
        end else if (adr == bscr_pkg::OFS_ROTARY) begin
            rdata_nxt[7:0] = ROTARY_POS;
        end else if (adr == bscr_pkg::OFS_BOOT_SIZE) begin
            rdata_nxt[1:0] = boot_size_r;
        end else if (adr == bscr_pkg::OFS_USER_SIZE) begin
            rdata_nxt[1:0] = user_size_r;
        end else if (adr == bscr_pkg::OFS_DISPLAY) begin
            rdata_nxt[7:0] = shadow_r;
        end else if (adr == bscr_pkg::OFS_VERSION) begin
            rdata_nxt[7:0] = VERSION;
        end else if (adr == bscr_pkg::OFS_MISC) begin
            rdata_nxt[bscr_pkg::MISC_PWDN] = pwdn_r;
            rdata_nxt[bscr_pkg::MISC_EJECT] = eject_r;
            rdata_nxt[bscr_pkg::MISC_RST_CLR] = rst_clr_r;
            rdata_nxt[bscr_pkg::MISC_KICK] = kick_r;
        end else if (adr == bscr_pkg::OFS_SWITCH) begin
            rdata_nxt[bscr_pkg::SW_BOOT_WP] = BOOT_PROTECT_SWITCH;
            rdata_nxt[bscr_pkg::SW_USER_WP] = USER_PROTECT_SWITCH;
            rdata_nxt[bscr_pkg::SW_FRONT_AUTO] = FRONT_TERMINATION_SWITCH;
            rdata_nxt[bscr_pkg::SW_BP_DIS] = BACKPLANE_TERMINATION_SWITCH;
        end else if (adr == bscr_pkg::OFS_RST_STAT) begin
            rdata_nxt[bscr_pkg::RST_W-1:0] = rst_stat_r;
        end else if (adr == bscr_pkg::OFS_IRQ_EN) begin
            rdata_nxt[bscr_pkg::NSRC-1:0] = irq_en_r;
        end else if (adr == bscr_pkg::OFS_IRQ_PEND) begin
            rdata_nxt[bscr_pkg::NSRC-1:0] = irq_bus.pend;
            rdata_nxt[bscr_pkg::PEND_WDO] = WATCHDOG_EXPIRY_OUTPUT_N;
            rdata_nxt[bscr_pkg::PEND_TEMP1] = TEMP1_ALARM_N;
            rdata_nxt[bscr_pkg::PEND_TEMP2] = TEMP2_ALARM_N;
        end
    end

    // Data is held after the ack so a slow master still sees it
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            rdata_r <= '0;
        end else if (rd_req) begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops
    assign WB_DAT_O = rdata_r;
    assign WB_ACK_O = ack_r;
    assign LED1_CTRL = led1_r;
    assign LED2_CTRL = led2_r;
    assign IDPROM_CTRL = idprom_r;
    assign BOOT_ROM_SIZE = boot_size_r;
    assign USER_ROM_SIZE = user_size_r;
    assign SEG_DISPLAY = display_r;
    assign MFIO_POWER_DOWN = pwdn_r;
    assign FLOPPY_EJECT = eject_r;
    assign WATCHDOG_KICK = kick_r;
    assign FRONT_TERM_EN = term_en_r;
    assign IRQ = irq_bus.irq;
endmodule

//--- core/bscr_pkg.sv
package bscr_pkg;
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int NSRC = 4;
    localparam int RST_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_LED1 = 8'h00;
    localparam logic [7:0] OFS_LED2 = 8'h04;
    localparam logic [7:0] OFS_IDPROM = 8'h08;
    localparam logic [7:0] OFS_ROTARY = 8'h0c;
    localparam logic [7:0] OFS_BOOT_SIZE = 8'h10;
    localparam logic [7:0] OFS_USER_SIZE = 8'h14;
    localparam logic [7:0] OFS_DISPLAY = 8'h18;
    localparam logic [7:0] OFS_VERSION = 8'h1c;
    localparam logic [7:0] OFS_MISC = 8'h20;
    localparam logic [7:0] OFS_SWITCH = 8'h24;
    localparam logic [7:0] OFS_RST_STAT = 8'h28;
    localparam logic [7:0] OFS_IRQ_EN = 8'h2c;
    localparam logic [7:0] OFS_IRQ_PEND = 8'h30;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int MISC_PWDN = 0;
    localparam int MISC_EJECT = 1;
    localparam int MISC_RST_CLR = 2;
    localparam int MISC_KICK = 3;
    localparam int SW_BOOT_WP = 0;
    localparam int SW_USER_WP = 1;
    localparam int SW_FRONT_AUTO = 2;
    localparam int SW_BP_DIS = 3;
    localparam int SRC_ENUM1 = 0;
    localparam int SRC_ENUM2 = 1;
    localparam int SRC_WDT = 2;
    localparam int SRC_TEMP = 3;
    localparam int PEND_WDO = 4;
    localparam int PEND_TEMP1 = 5;
    localparam int PEND_TEMP2 = 6;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_SIZE = 2'h0;
    localparam logic [3:0] RST_EN = 4'h0;
    // Arbitrary neutral version code
    localparam logic [7:0] VERSION_CODE = 8'h01;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bscr_bus_t;
endpackage

//--- core/bscr_irq_if.sv
interface bscr_irq_if;
    logic [bscr_pkg::NSRC-1:0] en;
    logic sw_wr;
    logic [1:0] sw_val;
    logic [bscr_pkg::NSRC-1:0] pend;
    logic irq;

    modport core (
        output en,
        output sw_wr,
        output sw_val,
        input pend,
        input irq
    );

    modport src (
        input en,
        input sw_wr,
        input sw_val,
        output pend,
        output irq
    );
endinterface

//--- core/bscr_irq.sv
module bscr_irq (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enum1_n,
    input wire logic enum2_n,
    input wire logic wdo_n,
    input wire logic temp1_n,
    input wire logic temp2_n,
    bscr_irq_if.src bus
);
    logic [1:0] sw_pend_r;
    logic [bscr_pkg::NSRC-1:0] pend_r;
    logic irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Software-set pending; the line itself is ORed in, so it is never lost
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sw_pend_r <= 2'h0;
        end else if (bus.sw_wr) begin
            sw_pend_r <= bus.sw_val;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_r <= '0;
        end else begin
            pend_r[bscr_pkg::SRC_ENUM1] <= ~enum1_n | sw_pend_r[0];
            pend_r[bscr_pkg::SRC_ENUM2] <= ~enum2_n | sw_pend_r[1];
            pend_r[bscr_pkg::SRC_WDT] <= ~wdo_n;
            pend_r[bscr_pkg::SRC_TEMP] <= ~temp1_n | ~temp2_n;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(pend_r & bus.en);
        end
    end

    assign bus.pend = pend_r;
    assign bus.irq = irq_r;
endmodule

//--- test/bscr_checker.sv
module bscr_checker #(
    parameter logic [7:0] VERSION = bscr_pkg::VERSION_CODE
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [bscr_pkg::ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [bscr_pkg::DAT_W-1:0] WB_DAT_I,
    input wire logic [bscr_pkg::DAT_W-1:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic FRONT_TERMINATION_SWITCH,
    input wire logic FRONT_CABLE_PRESENT,
    input wire logic [7:0] LED1_CTRL,
    input wire logic [1:0] BOOT_ROM_SIZE,
    input wire logic [7:0] SEG_DISPLAY,
    input wire logic MFIO_POWER_DOWN,
    input wire logic FLOPPY_EJECT,
    input wire logic WATCHDOG_KICK,
    input wire logic FRONT_TERM_EN,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);
    ////////////////////////////////////////////////////////////
    // A request is taken only outside the slave's ack cycle
    logic take;
    logic wr;
    assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr = take && WB_WE_I && WB_SEL_I[0];
    ////////////////////////////////////////////////////////////
    ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held over one cycle");
    ack_answer_a: assert property (take |=> WB_ACK_O)
        else $error("request not acknowledged");
    led1_write_a: assert property (
        wr && WB_ADR_I == bscr_pkg::OFS_LED1 |=> LED1_CTRL == $past(WB_DAT_I[7:0]))
        else $error("led1 not loaded");
    size_write_a: assert property (
        wr && WB_ADR_I == bscr_pkg::OFS_BOOT_SIZE |=> BOOT_ROM_SIZE == $past(WB_DAT_I[1:0]))
        else $error("boot size not loaded");
    display_drive_a: assert property (
        wr && WB_ADR_I == bscr_pkg::OFS_DISPLAY |=> SEG_DISPLAY == $past(WB_DAT_I[7:0]))
        else $error("display not loaded");
    version_read_a: assert property (
        take && !WB_WE_I && WB_ADR_I == bscr_pkg::OFS_VERSION |=> WB_DAT_O == {24'h0, VERSION})
        else $error("version code wrong");
    misc_write_a: assert property (
        wr && WB_ADR_I == bscr_pkg::OFS_MISC
        |=> {FLOPPY_EJECT, MFIO_POWER_DOWN} == $past(WB_DAT_I[1:0]))
        else $error("misc bits not loaded");
    kick_hold_a: assert property (
        !(wr && WB_ADR_I == bscr_pkg::OFS_MISC) |=> $stable(WATCHDOG_KICK))
        else $error("kick moved without a write");
    front_term_a: assert property (
        $past(RESETN) |=> FRONT_TERM_EN ==
        ($past(FRONT_TERMINATION_SWITCH) && !$past(FRONT_CABLE_PRESENT)))
        else $error("front termination wrong");
    reset_quiet_a: assert property (@(posedge CLK_SYS) disable iff (1'b0)
        !RESETN |=> !IRQ && !WB_ACK_O && LED1_CTRL == 8'h00 && !FRONT_TERM_EN)
        else $error("outputs not cleared by reset");
endmodule

bind bscr_top bscr_checker #(.VERSION(VERSION)) chk_i (
    .CLK_SYS(CLK_SYS), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .FRONT_CABLE_PRESENT(FRONT_CABLE_PRESENT),
    .FRONT_TERMINATION_SWITCH(FRONT_TERMINATION_SWITCH), .LED1_CTRL(LED1_CTRL),
    .BOOT_ROM_SIZE(BOOT_ROM_SIZE), .SEG_DISPLAY(SEG_DISPLAY), .FLOPPY_EJECT(FLOPPY_EJECT),
    .MFIO_POWER_DOWN(MFIO_POWER_DOWN), .WATCHDOG_KICK(WATCHDOG_KICK),
    .FRONT_TERM_EN(FRONT_TERM_EN), .IRQ(IRQ)
);

//--- test/board_system_config_registers_tb.sv
module board_system_config_registers_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] VER = 8'h5a;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic ack;
    logic [7:0] rotary = 8'h00;
    logic [3:0] sw = 4'h0;
    logic cable = 1'b0;
    logic [3:0] cause = 4'h0;
    logic [4:0] line_n = 5'h1f;
    logic [7:0] led1, led2, idprom, seg;
    logic [1:0] boot_size, user_size;
    logic pwdn, eject, kick, term_en, irq;
    int failures = 0;
    int checks = 0;
    int cycles = 0;

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    bscr_top #(.VERSION(VER)) dut (
        .CLK_SYS(clk_sys), .RESETN(resetn), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .ROTARY_POS(rotary),
        .BOOT_PROTECT_SWITCH(sw[0]), .USER_PROTECT_SWITCH(sw[1]),
        .FRONT_TERMINATION_SWITCH(sw[2]), .BACKPLANE_TERMINATION_SWITCH(sw[3]),
        .FRONT_CABLE_PRESENT(cable), .RESET_CAUSE(cause), .ENUM1_N(line_n[0]),
        .ENUM2_N(line_n[1]), .WATCHDOG_EXPIRY_OUTPUT_N(line_n[2]),
        .TEMP1_ALARM_N(line_n[3]), .TEMP2_ALARM_N(line_n[4]), .LED1_CTRL(led1),
        .LED2_CTRL(led2), .IDPROM_CTRL(idprom), .BOOT_ROM_SIZE(boot_size),
        .USER_ROM_SIZE(user_size), .SEG_DISPLAY(seg), .MFIO_POWER_DOWN(pwdn),
        .FLOPPY_EJECT(eject), .WATCHDOG_KICK(kick), .FRONT_TERM_EN(term_en), .IRQ(irq)
    );
    ////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("[FAIL] %0t timeout", $time);
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Ack and read data are taken at the rising edge that also ends the request
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= d;
        sel <= s;
        do @(posedge clk_sys); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        chk(rd, e);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    function automatic logic [31:0] pend_exp(input logic [4:0] n);
        return {25'h0, n[4], n[3], n[2], ~(n[3] & n[4]), ~n[2], ~n[1], ~n[0]};
    endfunction
    ////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] ofs [3] = '{bscr_pkg::OFS_LED1, bscr_pkg::OFS_LED2, bscr_pkg::OFS_IDPROM};
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, ofs[i], 32'h0000_01a0 + 32'(i), 4'hf);
        end
        // Lane 0 off must leave the register alone
        wb(1'b1, bscr_pkg::OFS_LED1, 32'h0000_00ff, 4'he);
        for (int i = 0; i < 3; i++) begin
            rdchk(ofs[i], 32'h0000_00a0 + 32'(i));
        end
        chk({8'h00, led1, led2, idprom}, 32'h00a0_a1a2);
        wb(1'b1, bscr_pkg::OFS_BOOT_SIZE, 32'h0000_00ff, 4'hf);
        wb(1'b1, bscr_pkg::OFS_USER_SIZE, 32'h0000_0002, 4'hf);
        rdchk(bscr_pkg::OFS_BOOT_SIZE, 32'h3);
        rdchk(bscr_pkg::OFS_USER_SIZE, 32'h2);
        chk({28'h0, boot_size, user_size}, 32'he);
    endtask

    task automatic t_ro();
        @(posedge clk_sys);
        rotary <= 8'h3c;
        wb(1'b1, bscr_pkg::OFS_ROTARY, 32'h0000_00ff, 4'hf);
        rdchk(bscr_pkg::OFS_ROTARY, 32'h3c);
        wb(1'b1, bscr_pkg::OFS_VERSION, 32'h0000_00ff, 4'hf);
        rdchk(bscr_pkg::OFS_VERSION, {24'h0, VER});
        wb(1'b1, bscr_pkg::OFS_DISPLAY, 32'h0000_007e, 4'hf);
        chk({24'h0, seg}, 32'h7e);
        rdchk(bscr_pkg::OFS_DISPLAY, 32'h7e);
        rdchk(8'h40, 32'h0);
    endtask

    task automatic t_misc();
        wb(1'b1, bscr_pkg::OFS_MISC, 32'h3, 4'hf);
        chk({30'h0, eject, pwdn}, 32'h3);
        wb(1'b1, bscr_pkg::OFS_MISC, 32'h9, 4'hf);
        chk({29'h0, kick, eject, pwdn}, 32'h5);
        rdchk(bscr_pkg::OFS_MISC, 32'h9);
        wb(1'b1, bscr_pkg::OFS_MISC, 32'h1, 4'hf);
        chk({31'h0, kick}, 32'h0);
        @(posedge clk_sys);
        cause <= 4'h5;
        @(posedge clk_sys);
        cause <= 4'h0;
        rdchk(bscr_pkg::OFS_RST_STAT, 32'h5);
        wb(1'b1, bscr_pkg::OFS_MISC, 32'h4, 4'hf);
        rdchk(bscr_pkg::OFS_RST_STAT, 32'h0);
        rdchk(bscr_pkg::OFS_MISC, 32'h0);
    endtask

    task automatic t_switch();
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            sw <= 4'(i);
            cable <= i[0];
            rdchk(bscr_pkg::OFS_SWITCH, 32'(i));
            chk({31'h0, term_en}, 32'(i[2] & ~i[0]));
        end
    endtask

    // Lines are level inputs: pending drops on the clock after a line goes high again
    task automatic t_irq();
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys);
            line_n <= ~(5'h01 << i);
            wait_n(3);
            chk({31'h0, irq}, 32'h0);
            rdchk(bscr_pkg::OFS_IRQ_PEND, pend_exp(~(5'h01 << i)));
            wb(1'b1, bscr_pkg::OFS_IRQ_EN, 32'h1 << ((i == 4) ? 3 : i), 4'hf);
            wait_n(3);
            chk({31'h0, irq}, 32'h1);
            @(posedge clk_sys);
            line_n <= 5'h1f;
            wait_n(3);
            chk({31'h0, irq}, 32'h0);
            wb(1'b1, bscr_pkg::OFS_IRQ_EN, 32'h0, 4'hf);
        end
        wb(1'b1, bscr_pkg::OFS_IRQ_EN, 32'h3, 4'hf);
        rdchk(bscr_pkg::OFS_IRQ_EN, 32'h3);
        wb(1'b1, bscr_pkg::OFS_IRQ_PEND, 32'h3, 4'hf);
        wait_n(3);
        chk({31'h0, irq}, 32'h1);
        rdchk(bscr_pkg::OFS_IRQ_PEND, 32'h73);
        wb(1'b1, bscr_pkg::OFS_IRQ_PEND, 32'h0, 4'hf);
        wait_n(3);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_second_reset();
        wb(1'b1, bscr_pkg::OFS_LED1, 32'h55, 4'hf);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        wait_n(0);
        chk({24'h0, led1}, 32'h0);
        rdchk(bscr_pkg::OFS_IRQ_EN, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        wait_n(0);
        chk({led1, led2, idprom, seg}, 32'h0);
        chk({25'h0, boot_size, user_size, pwdn, eject, kick}, 32'h0);
        rdchk(bscr_pkg::OFS_IRQ_EN, 32'h0);
        t_regs();
        t_ro();
        t_misc();
        t_switch();
        t_irq();
        t_second_reset();
        close_out();
    end
endmodule
